// file: verification/oges_chk.sv
`timescale 1ns/100ps
`default_nettype none
module oges_chk (
    input wire logic                i_mclk,
    input wire logic                i_rst,
    input wire logic [1:0]          i_htrans,
    input wire logic                i_hwrite,
    input wire oges_pkg::oges_src_t i_src,
    input wire logic [31:0]         o_hrdata,
    input wire logic                o_hreadyout,
    input wire logic                o_hresp,
    input wire oges_pkg::oges_evt_t o_evt
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bad bus answer");
    rst_clear_a: assert property ($fell(i_rst) |-> o_evt == 0 && o_hrdata == 0) else $error("not clear");
    rd_phase_a: assert property (o_hrdata != 0 |-> $past(i_htrans == 2'h2 && !i_hwrite)) else $error("rdata");
    rd_width_a: assert property (o_hrdata[31:8] == 0) else $error("upper bits");
    lvl_rise_a: assert property (o_evt.rise |-> |$past(i_src.rise_src, 3)) else $error("rise");
    edge_rise_a: assert property (o_evt.rise_delayed |-> |($past(i_src.rise_src, 3) & ~$past(i_src.rise_src, 4)))
        else $error("rise edge");
    lvl_fall_a: assert property (o_evt.fall |-> !(&$past(i_src.fall_src, 3))) else $error("fall");
    edge_fall_a: assert property (o_evt.fall_delayed |-> |(~$past(i_src.fall_src, 3) & $past(i_src.fall_src, 4)))
        else $error("fall edge");
endmodule
bind oges_event_select oges_chk oges_chk_inst (.i_mclk, .i_rst, .i_htrans, .i_hwrite, .i_src, .o_hrdata,
    .o_hreadyout, .o_hresp, .o_evt);
`default_nettype wire

// file: verification/oges_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// Peripheral outputs change only on the clock, like on-chip sources
module oges_src_model (
    input wire logic                i_mclk,
    input wire oges_pkg::oges_src_t i_want,
    output oges_pkg::oges_src_t     o_src
);
    always_ff @(posedge i_mclk) o_src <= i_want;
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                clk = 0, rst = 1, hsel = 0, hwrite = 0, ready, resp;
    logic [31:0]         haddr = 0, hwdata = 0, hrdata, got, n;
    logic [1:0]          htrans = 0;
    oges_pkg::oges_src_t want = '0, src;
    oges_pkg::oges_evt_t evt;
    int                  bad_count = 0, check_count = 0, cyc = 0;
    oges_src_model oges_src_model_inst (.i_mclk(clk), .i_want(want), .o_src(src));
    oges_event_select oges_event_select_inst (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(oges_pkg::HSIZE_WORD),
        .i_hwdata(hwdata), .i_hready(ready), .o_hrdata(hrdata), .o_hreadyout(ready), .o_hresp(resp),
        .i_src(src), .o_evt(evt));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= oges_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (ready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (ready !== 1'b1);
        got = hrdata;
    endtask
    // Source path is model register plus sync plus output register, so six edges is settled
    task automatic ev(input logic [3:0] e);
        repeat (6) @(posedge clk);
        chk({28'h0, evt}, {28'h0, e});
    endtask
    task t_regs;
        bus(0, oges_pkg::RISE_MODE_LO_OFFS, 0);
        chk(got, 0);
        bus(0, oges_pkg::FALL_EN_LO_OFFS, 0);
        chk(got, 0);
        bus(1, oges_pkg::RISE_MODE_HI_OFFS, 32'hFF);
        bus(0, oges_pkg::RISE_MODE_HI_OFFS, 0);
        chk(got, 32'hFF);
        bus(0, 8'h40, 0);
        chk(got, 0);
        $display("regs done");
    endtask
    task t_rise;
        bus(1, oges_pkg::RISE_EN_LO_OFFS, 32'h1);
        want.rise_src <= 16'h0001;
        ev(4'h8);
        want.rise_src <= 16'h0002;
        ev(4'h0);
        bus(1, oges_pkg::RISE_MODE_LO_OFFS, 32'h3);
        want.rise_src <= 16'h0001;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            n += evt.rise_delayed;
        end
        chk(n, 1);
        $display("rise done");
    endtask
    task t_fall;
        want.fall_src <= 8'hFF;
        bus(1, oges_pkg::FALL_EN_LO_OFFS, 32'h81);
        ev(4'h0);
        want.fall_src <= 8'h7F;
        ev(4'h2);
        bus(0, oges_pkg::STATUS_OFFS, 0);
        chk(got, 32'h2);
        want.fall_src <= 8'h7E;
        ev(4'h2);
        bus(1, oges_pkg::FALL_EN_LO_OFFS, 0);
        ev(4'h0);
        $display("fall done");
    endtask
    // Edge mode on the pin source: one high-to-low step gives exactly one delayed pulse
    task t_fedge;
        want.fall_src <= 8'hFF;
        bus(1, oges_pkg::FALL_MODE_LO_OFFS, 32'h1);
        bus(1, oges_pkg::FALL_EN_LO_OFFS, 32'h1);
        ev(4'h0);
        want.fall_src <= 8'hFE;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            n += evt.fall_delayed;
        end
        chk(n, 1);
        $display("fall edge done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        t_regs();
        t_rise();
        t_fall();
        t_fedge();
        give_verdict();
    end
endmodule
`default_nettype wire

// file: verilog/oges_event_select.sv
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module oges_event_select #(
    parameter bit HAS_SRC15 = 1'b1
) (
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    input  wire logic                i_hsel,
    input  wire logic [31:0]         i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [31:0]         i_hwdata,
    input  wire logic                i_hready,
    output logic [31:0]              o_hrdata,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    input  wire oges_pkg::oges_src_t i_src,
    output oges_pkg::oges_evt_t      o_evt
);
    logic [7:0]  rmode_lo_q, rmode_hi_q, ren_lo_q, ren_hi_q, fen_q, fmode_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;
    oges_pkg::oges_src_t sync1_q, sync2_q, last_q;
    oges_pkg::oges_evt_t evt_q;

    wire logic        acc_take  = i_hsel & i_hready & (i_htrans == oges_pkg::HTRANS_NONSEQ);
    wire logic        wr_take   = acc_take & i_hwrite;
    wire logic        rd_take   = acc_take & ~i_hwrite;
    wire logic [7:0]  acc_addr  = i_haddr[7:0];
    wire logic [15:0] rise_en   = {ren_hi_q, ren_lo_q};
    // Smaller variant forces the source 15 mode bit to zero on write and on read
    // source 15 mask
    wire logic [7:0]  hi_mask   = HAS_SRC15 ? 8'hFF : 8'h7F;
    // pin and comparator 1 in low bits
    wire logic [15:0] rise_mode = {rmode_hi_q & hi_mask, rmode_lo_q};
    wire logic [15:0] rise_edge = sync2_q.rise_src & ~last_q.rise_src;
    wire logic [7:0]  fall_edge = ~sync2_q.fall_src & last_q.fall_src;

    wire logic [15:0] rise_edge_q = rise_en & rise_mode & rise_edge;
    wire logic [15:0] rise_lvl_q  = rise_en & ~rise_mode & sync2_q.rise_src;
    // bit order pin, comparators, capture units, pulse unit 3
    wire logic [7:0]  fall_edge_q = fen_q & fmode_q & fall_edge;
    wire logic [7:0]  fall_lvl_q  = fen_q & ~fmode_q & ~sync2_q.fall_src;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            oges_pkg::RISE_MODE_LO_OFFS: rd_mux = {24'h000000, rmode_lo_q};
            oges_pkg::RISE_MODE_HI_OFFS: rd_mux = {24'h000000, rmode_hi_q & hi_mask};
            oges_pkg::RISE_EN_LO_OFFS:   rd_mux = {24'h000000, ren_lo_q};
            oges_pkg::RISE_EN_HI_OFFS:   rd_mux = {24'h000000, ren_hi_q};
            oges_pkg::FALL_EN_LO_OFFS:   rd_mux = {24'h000000, fen_q};
            oges_pkg::FALL_MODE_LO_OFFS: rd_mux = {24'h000000, fmode_q};
            oges_pkg::STATUS_OFFS:       rd_mux = {28'h0000000, evt_q};
            default:                     rd_mux = 32'h00000000;
        endcase
    endfunction

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_q;
    assign o_evt       = evt_q;

    // Bus slave: zero wait states, write data lands in the data phase
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h00000000;
        end else if (i_ce) begin
            wr_pend_q <= wr_take;
            wr_addr_q <= acc_addr;
            rdata_q   <= rd_take ? rd_mux(acc_addr) : 32'h00000000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rmode_lo_q <= oges_pkg::REG_RESET;
            rmode_hi_q <= oges_pkg::REG_RESET;
            ren_lo_q   <= oges_pkg::REG_RESET;
            ren_hi_q   <= oges_pkg::REG_RESET;
            fen_q      <= oges_pkg::REG_RESET;
            fmode_q    <= oges_pkg::REG_RESET;
        end else if (i_ce && wr_pend_q) begin
            if (wr_addr_q == oges_pkg::RISE_MODE_LO_OFFS) rmode_lo_q <= i_hwdata[7:0];
            if (wr_addr_q == oges_pkg::RISE_MODE_HI_OFFS) rmode_hi_q <= i_hwdata[7:0] & hi_mask;
            if (wr_addr_q == oges_pkg::RISE_EN_LO_OFFS)   ren_lo_q   <= i_hwdata[7:0];
            if (wr_addr_q == oges_pkg::RISE_EN_HI_OFFS)   ren_hi_q   <= i_hwdata[7:0];
            if (wr_addr_q == oges_pkg::FALL_EN_LO_OFFS)   fen_q      <= i_hwdata[7:0];
            if (wr_addr_q == oges_pkg::FALL_MODE_LO_OFFS) fmode_q    <= i_hwdata[7:0];
        end
    end

    // Sources come from other logic blocks; synchronised to be safe
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            last_q  <= '0;
        end else if (i_ce) begin
            sync1_q <= i_src;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            evt_q <= '0;
        end else if (i_ce) begin
            evt_q.rise         <= |rise_lvl_q;
            evt_q.rise_delayed <= |rise_edge_q;
            evt_q.fall         <= |fall_lvl_q;
            evt_q.fall_delayed <= |fall_edge_q;
        end
    end
endmodule
`default_nettype wire

// file: verilog/oges_pkg.sv
package oges_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] RISE_MODE_LO_OFFS = 8'h00;
    localparam logic [7:0] RISE_MODE_HI_OFFS = 8'h04;
    localparam logic [7:0] RISE_EN_LO_OFFS   = 8'h08;
    localparam logic [7:0] RISE_EN_HI_OFFS   = 8'h0C;
    localparam logic [7:0] FALL_EN_LO_OFFS   = 8'h10;
    localparam logic [7:0] FALL_MODE_LO_OFFS = 8'h14;
    localparam logic [7:0] STATUS_OFFS       = 8'h18;
    localparam logic [7:0] REG_RESET         = 8'h00;
    // Bit 7 of the high rising mode register: source 15
    localparam int         SRC15_POS         = 7;
    localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;
    localparam logic [2:0] HSIZE_WORD        = 3'h2;

    typedef struct packed {
        logic [15:0] rise_src;
        logic [7:0]  fall_src;
    } oges_src_t;

    typedef struct packed {
        logic rise;
        logic rise_delayed;
        logic fall;
        logic fall_delayed;
    } oges_evt_t;
endpackage
